// ==== inc/qup_pkg.sv ====
// Shared constants and types for the quad UART pin interface.
// Assumes a single 125 MHz clock on both ends of the host bus.
package qup_pkg;
  // Clock and baud range
  localparam int QUP_CLK_HZ = 125000000;
  localparam int QUP_BAUD_MIN_HZ = 50;
  localparam int QUP_BAUD_MAX_HZ = 1500000;
  localparam int QUP_PRESCALE = 3; // Lets a 16-bit divisor reach 50 Hz
  localparam logic [1:0] QUP_PRE_LAST = 2'(QUP_PRESCALE - 1);
  localparam int QUP_OVS = 16; // Oversample ticks per bit
  localparam logic [3:0] QUP_MID = 4'h7;
  localparam logic [3:0] QUP_LAST = 4'(QUP_OVS - 1);
  localparam int QUP_DEPTH = 16;
  localparam logic [3:0] QUP_WL_BASE = 4'h5;
  localparam logic [3:0] QUP_WL_FULL = 4'h8;
  // Register selects
  localparam logic [2:0] QUP_A_DATA = 3'h0;
  localparam logic [2:0] QUP_A_IER = 3'h1;
  localparam logic [2:0] QUP_A_ISR = 3'h2;
  localparam logic [2:0] QUP_A_LCR = 3'h3;
  localparam logic [2:0] QUP_A_MCR = 3'h4;
  localparam logic [2:0] QUP_A_LSR = 3'h5;
  localparam logic [2:0] QUP_A_MSR = 3'h6;
  localparam logic [2:0] QUP_A_SPR = 3'h7;
  // Field positions
  localparam int QUP_LCR_DLAB = 7;
  localparam int QUP_LCR_BRK = 6;
  localparam int QUP_LCR_STICK = 5;
  localparam int QUP_LCR_EVEN = 4;
  localparam int QUP_LCR_PEN = 3;
  localparam int QUP_LCR_STOP2 = 2;
  localparam int QUP_MCR_LOOP = 4;
  localparam int QUP_MCR_IRQ_EN = 3;
  localparam int QUP_MCR_SEND = 1;
  localparam int QUP_MCR_TERM = 0;
  localparam int QUP_FCR_EN = 0;
  localparam int QUP_FCR_RXCLR = 1;
  localparam int QUP_FCR_TXCLR = 2;
  localparam int QUP_IER_RX = 0;
  localparam int QUP_IER_TX = 1;
  localparam int QUP_IER_LINE = 2;
  // Reset values and interrupt codes
  localparam logic [7:0] QUP_RST_BYTE = 8'h00;
  localparam logic [15:0] QUP_RST_DIV = 16'h0001;
  localparam logic [3:0] QUP_ISR_NONE = 4'h1;
  localparam logic [3:0] QUP_ISR_LINE = 4'h6;
  localparam logic [3:0] QUP_ISR_RXD = 4'h4;
  localparam logic [3:0] QUP_ISR_THRE = 4'h2;
  localparam logic [1:0] QUP_ISR_FIFO = 2'h3;
  // Serial framing states
  typedef enum logic [2:0] {
    QUP_S_IDLE = 3'b000,
    QUP_S_START = 3'b001,
    QUP_S_DATA = 3'b010,
    QUP_S_PAR = 3'b011,
    QUP_S_STOP = 3'b100
  } qup_ser_t;
  // Host bus cycle states
  typedef enum logic [1:0] {
    QUP_H_IDLE = 2'b00,
    QUP_H_SETUP = 2'b01,
    QUP_H_STROBE = 2'b10,
    QUP_H_HOLD = 2'b11
  } qup_hst_t;
endpackage

// ==== inc/qup_if.sv ====
// Host bus of one UART channel, between host end and device end.
// The shared data wire is resolved here from the two output enables.
`timescale 1ns/1ps
interface qup_if;
  logic cs_n;
  logic write_strobe_n;
  logic read_strobe_n;
  logic reg_sel_2;
  logic reg_sel_1;
  logic reg_sel_0;
  logic [7:0] host_dout;
  logic host_oe_n;
  logic [7:0] dev_dout;
  logic dev_oe_n;
  logic [7:0] host_data_bus;
  // Device wins if both drive; an idle bus floats high
  assign host_data_bus = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 8'hFF);
  modport dev (
    input cs_n, write_strobe_n, read_strobe_n, reg_sel_2, reg_sel_1, reg_sel_0, host_data_bus,
    output dev_dout, dev_oe_n
  );
  modport host (
    output cs_n, write_strobe_n, read_strobe_n, reg_sel_2, reg_sel_1, reg_sel_0, host_dout, host_oe_n,
    input host_data_bus
  );
endinterface

// ==== rtl/qup_fifo.sv ====
// Character queue used for both directions of a channel.
// Assumes push is ignored when full and pop when empty.
`timescale 1ns/1ps
module qup_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("qup_fifo depth must be a power of two");
  end

  ////////////////////////////////////////////////////////////////
  // Extra pointer bit tells full from empty
  assign empty = (wp == rp);
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign head = mem[rp[AW-1:0]];

  // Pointers; clear drops everything queued
  always_ff @(posedge clk)
  begin
    if (reset || clear)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push && !full)
        wp <= wp + 1'b1;
      if (pop && !empty)
        rp <= rp + 1'b1;
    end
  end

  // Storage has no reset; pointers guard it
  always_ff @(posedge clk)
  begin
    if (push && !full)
      mem[wp[AW-1:0]] <= din;
  end
endmodule // qup_fifo

// ==== rtl/qup_device.sv ====
// One UART channel: host register bus, baud generator, framing, queues.
// Assumes pins and host bus come from outside the clock domain.
`timescale 1ns/1ps
// Functional notes
// - Separate 16-byte queues; receive keeps error flags
// - Bit rates from 50 Hz to 1.5 MHz
// - Even, odd or no parity both ways
// - Bus bit zero is first serial bit
// - High line is one, low is zero
// - Loopback ignores pin, feeds transmit into receiver
// - Serial output high in reset, loopback, idle without break
// - Transfers only while channel select is low
// - Write strobe loads bus into selected register
// - Read strobe drives register, else bus released
// - Host sets register select before strobe
// - Transmit-space output high when queue full
// - Receive output low when queue full
// - Style pin high: interrupt always driven
// - Style pin low: drive only when enabled
// - Interrupt on enabled error, data, empty
// - Control bit one drives send-request low
// - Control bit zero drives terminal-ready low
// - Clock input feeds baud generator and logic
// - Reset clears outputs, disables line directions
module qup_device #(
  parameter int DEPTH = qup_pkg::QUP_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  qup_if.dev bus,
  input wire logic rx_in,
  input wire logic irq_style_pin,
  output logic tx_out,
  output logic send_req_n,
  output logic term_ready_n,
  output logic tx_space_n,
  output logic rx_avail_n,
  output logic int_out,
  output logic int_oe_n
);
  logic [15:0] s1;
  logic [15:0] s2;
  logic [7:0] ier, lcr, modem_ctrl_reg, spr, dll, dlm, rd_q;
  logic fifo_en, wr_prev, rd_prev, ovr, tick, tx_par;
  logic [1:0] pre;
  logic [15:0] div_cnt;
  qup_pkg::qup_ser_t tx_st, rx_st;
  logic [3:0] tx_sub, rx_sub;
  logic [2:0] tx_bit, rx_bit;
  logic [7:0] tx_sh, rx_sh;
  logic rx_pe;
  logic [7:0] tx_head;
  logic [10:0] rx_head;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic tx_pop, rx_push;
  logic [10:0] rx_din;
  logic [7:0] rd_view [8];

  if ((qup_pkg::QUP_CLK_HZ / (qup_pkg::QUP_PRESCALE * qup_pkg::QUP_OVS * 65535)) > qup_pkg::QUP_BAUD_MIN_HZ ||
      (qup_pkg::QUP_CLK_HZ / (qup_pkg::QUP_PRESCALE * qup_pkg::QUP_OVS)) < qup_pkg::QUP_BAUD_MAX_HZ || DEPTH < 16)
  begin : g_chk
    $error("qup_device cannot serve the bit-rate range or queue depth");
  end

  // Masks a byte to the programmed word length
  function automatic logic [7:0] wl_mask(input logic [7:0] d, input logic [1:0] wl);
    return d & ~(8'hFF << (qup_pkg::QUP_WL_BASE + {2'h0, wl}));
  endfunction

  // Parity bit for a character under the current line control
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = wl_mask(d, lc[1:0]);
    return lc[qup_pkg::QUP_LCR_STICK] ? ~lc[qup_pkg::QUP_LCR_EVEN] :
           (lc[qup_pkg::QUP_LCR_EVEN] ? ^m : ~^m);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for all pins; strobes idle high in reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= 16'hFFFF;
      s2 <= 16'hFFFF;
    end
    else
    begin
      s1 <= {bus.cs_n, bus.write_strobe_n, bus.read_strobe_n, bus.reg_sel_2, bus.reg_sel_1,
             bus.reg_sel_0, bus.host_data_bus, rx_in, irq_style_pin};
      s2 <= s1;
    end
  end

  // Synchronised view of the bus and decode
  wire sel = ~s2[15];
  wire wr_act = sel & ~s2[14];
  wire rd_act = sel & ~s2[13];
  wire [2:0] addr = s2[12:10];
  wire [7:0] din = s2[9:2];
  wire rx_pin = s2[1];
  wire style = s2[0];
  wire wr_go = wr_act & ~wr_prev;
  wire rd_go = rd_act & ~rd_prev;
  wire dlab = lcr[qup_pkg::QUP_LCR_DLAB];
  wire loop = modem_ctrl_reg[qup_pkg::QUP_MCR_LOOP];
  wire a_data = (addr == qup_pkg::QUP_A_DATA);
  wire a_ier = (addr == qup_pkg::QUP_A_IER);
  wire tx_push = wr_go & a_data & ~dlab;
  wire rx_pop = rd_go & a_data & ~dlab;
  wire fcr_we = wr_go & (addr == qup_pkg::QUP_A_ISR);
  wire tx_clr = fcr_we & din[qup_pkg::QUP_FCR_TXCLR];
  wire rx_clr = fcr_we & din[qup_pkg::QUP_FCR_RXCLR];
  wire [3:0] nbits = qup_pkg::QUP_WL_BASE + {2'h0, lcr[1:0]};

  ////////////////////////////////////////////////////////////////
  // Register writes on the first synchronised cycle of the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      {ier, lcr, modem_ctrl_reg, spr} <= {4{qup_pkg::QUP_RST_BYTE}};
      {dlm, dll} <= qup_pkg::QUP_RST_DIV;
      fifo_en <= 1'b0;
      {wr_prev, rd_prev} <= 2'b00;
    end
    else
    begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
      if (wr_go && a_data && dlab) dll <= din;
      if (wr_go && a_ier && dlab) dlm <= din;
      if (wr_go && a_ier && !dlab) ier <= din;
      if (wr_go && addr == qup_pkg::QUP_A_LCR) lcr <= din;
      if (wr_go && addr == qup_pkg::QUP_A_MCR) modem_ctrl_reg <= din;
      if (wr_go && addr == qup_pkg::QUP_A_SPR) spr <= din;
      if (fcr_we) fifo_en <= din[qup_pkg::QUP_FCR_EN];
    end
  end

  // Status views; head error flags only count while a character waits, overrun counts always
  wire [2:0] head_err = rx_empty ? 3'h0 : rx_head[10:8];
  wire line_evt = ovr | (|head_err);
  wire [7:0] lsr = {line_evt, tx_empty & (tx_st == qup_pkg::QUP_S_IDLE), tx_empty,
                    head_err[2], head_err[1], head_err[0], ovr, ~rx_empty};
  wire irq_line = ier[qup_pkg::QUP_IER_LINE] & line_evt;
  wire irq_rxd = ier[qup_pkg::QUP_IER_RX] & ~rx_empty;
  wire irq_thre = ier[qup_pkg::QUP_IER_TX] & tx_empty;
  wire [3:0] isr_code = irq_line ? qup_pkg::QUP_ISR_LINE : irq_rxd ? qup_pkg::QUP_ISR_RXD :
                        irq_thre ? qup_pkg::QUP_ISR_THRE : qup_pkg::QUP_ISR_NONE;
  assign rd_view[0] = dlab ? dll : rx_head[7:0];
  assign rd_view[1] = dlab ? dlm : {4'h0, ier[3:0]};
  assign rd_view[2] = {fifo_en ? qup_pkg::QUP_ISR_FIFO : 2'h0, 2'h0, isr_code};
  assign rd_view[3] = lcr;
  assign rd_view[4] = {3'h0, modem_ctrl_reg[4:0]};
  assign rd_view[5] = lsr;
  assign rd_view[6] = 8'h00; // Modem inputs not wired to this channel
  assign rd_view[7] = spr;

  // Read data is frozen at the strobe's first cycle; oe follows the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rd_q <= qup_pkg::QUP_RST_BYTE;
    else if (rd_go)
      rd_q <= rd_view[addr];
  end
  assign bus.dev_dout = rd_q;
  assign bus.dev_oe_n = ~rd_act;

  // Overrun: a lost character wins over the status read that clears it
  always_ff @(posedge clk)
  begin
    if (reset)
      ovr <= 1'b0;
    else
      ovr <= (rx_push & rx_full) | (ovr & ~(rd_go & addr == qup_pkg::QUP_A_LSR));
  end

  ////////////////////////////////////////////////////////////////
  // Baud generator: prescale enable, then divisor, gives 16x tick
  wire pre_tick = (pre == qup_pkg::QUP_PRE_LAST);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre <= 2'h0;
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      pre <= pre_tick ? 2'h0 : pre + 2'h1;
      tick <= pre_tick && div_cnt <= 16'h0001;
      if (pre_tick)
        div_cnt <= (div_cnt <= 16'h0001) ? {dlm, dll} : div_cnt - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Queues: 8 data bits out, data plus three error flags in
  qup_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .clk(clk), .reset(reset), .clear(tx_clr), .push(tx_push), .din(din),
    .pop(tx_pop), .head(tx_head), .full(tx_full), .empty(tx_empty));
  qup_fifo #(.W(11), .DEPTH(DEPTH)) u_rxq (
    .clk(clk), .reset(reset), .clear(rx_clr), .push(rx_push), .din(rx_din),
    .pop(rx_pop), .head(rx_head), .full(rx_full), .empty(rx_empty));

  ////////////////////////////////////////////////////////////////
  // Transmitter framing
  assign tx_pop = (tx_st == qup_pkg::QUP_S_IDLE) & ~tx_empty;
  wire tx_line = lcr[qup_pkg::QUP_LCR_BRK] ? 1'b0 :
                 (tx_st == qup_pkg::QUP_S_START) ? 1'b0 :
                 (tx_st == qup_pkg::QUP_S_DATA) ? tx_sh[0] :
                 (tx_st == qup_pkg::QUP_S_PAR) ? tx_par : 1'b1;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_st <= qup_pkg::QUP_S_IDLE;
      {tx_sub, tx_bit, tx_sh, tx_par} <= '0;
    end
    else if (tx_st == qup_pkg::QUP_S_IDLE)
    begin
      if (tx_pop)
      begin
        tx_sh <= tx_head;
        tx_par <= par_bit(tx_head, lcr);
        {tx_sub, tx_bit} <= '0;
        tx_st <= qup_pkg::QUP_S_START;
      end
    end
    else if (tick)
    begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_sub == qup_pkg::QUP_LAST)
        unique case (tx_st)
          qup_pkg::QUP_S_START: tx_st <= qup_pkg::QUP_S_DATA;
          qup_pkg::QUP_S_DATA:
          begin
            tx_sh <= tx_sh >> 1;
            tx_bit <= tx_bit + 3'h1;
            if ({1'b0, tx_bit} == nbits - 4'h1)
            begin
              tx_bit <= 3'h0;
              tx_st <= lcr[qup_pkg::QUP_LCR_PEN] ? qup_pkg::QUP_S_PAR : qup_pkg::QUP_S_STOP;
            end
          end
          qup_pkg::QUP_S_PAR: tx_st <= qup_pkg::QUP_S_STOP;
          qup_pkg::QUP_S_STOP:
          begin
            tx_bit <= 3'h1;
            if (!lcr[qup_pkg::QUP_LCR_STOP2] || tx_bit != 3'h0)
              tx_st <= qup_pkg::QUP_S_IDLE;
          end
          default: tx_st <= qup_pkg::QUP_S_IDLE;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Receiver: centre the start bit, then sample every 16 ticks
  wire rx_line = loop ? tx_line : rx_pin;
  wire [7:0] rx_data = rx_sh >> (qup_pkg::QUP_WL_FULL - nbits);
  assign rx_push = tick & (rx_st == qup_pkg::QUP_S_STOP) & (rx_sub == qup_pkg::QUP_LAST);
  assign rx_din = {~rx_line & (rx_data == 8'h00), ~rx_line, rx_pe, rx_data};
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_st <= qup_pkg::QUP_S_IDLE;
      {rx_sub, rx_bit, rx_sh, rx_pe} <= '0;
    end
    else if (tick)
      unique case (rx_st)
        qup_pkg::QUP_S_IDLE:
          if (!rx_line)
          begin
            rx_sub <= 4'h0;
            rx_pe <= 1'b0;
            rx_st <= qup_pkg::QUP_S_START;
          end
        qup_pkg::QUP_S_START:
        begin
          rx_sub <= (rx_sub == qup_pkg::QUP_MID) ? 4'h0 : rx_sub + 4'h1;
          rx_bit <= 3'h0;
          if (rx_sub == qup_pkg::QUP_MID) // Glitch shorter than half a bit is dropped
            rx_st <= rx_line ? qup_pkg::QUP_S_IDLE : qup_pkg::QUP_S_DATA;
        end
        qup_pkg::QUP_S_DATA, qup_pkg::QUP_S_PAR, qup_pkg::QUP_S_STOP:
        begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == qup_pkg::QUP_LAST)
          begin
            if (rx_st == qup_pkg::QUP_S_DATA)
            begin
              rx_sh <= {rx_line, rx_sh[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if ({1'b0, rx_bit} == nbits - 4'h1)
                rx_st <= lcr[qup_pkg::QUP_LCR_PEN] ? qup_pkg::QUP_S_PAR : qup_pkg::QUP_S_STOP;
            end
            else if (rx_st == qup_pkg::QUP_S_PAR)
            begin
              rx_pe <= rx_line ^ par_bit(rx_data, lcr);
              rx_st <= qup_pkg::QUP_S_STOP;
            end
            else
              rx_st <= qup_pkg::QUP_S_IDLE;
          end
        end
        default: rx_st <= qup_pkg::QUP_S_IDLE;
      endcase
  end

  ////////////////////////////////////////////////////////////////
  // Pin outputs, all registered
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_out <= 1'b1;
      {send_req_n, term_ready_n} <= 2'b11;
      tx_space_n <= 1'b0;
      rx_avail_n <= 1'b1;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
    end
    else
    begin
      tx_out <= loop ? 1'b1 : tx_line;
      send_req_n <= ~modem_ctrl_reg[qup_pkg::QUP_MCR_SEND];
      term_ready_n <= ~modem_ctrl_reg[qup_pkg::QUP_MCR_TERM];
      tx_space_n <= tx_full;
      rx_avail_n <= ~rx_full;
      int_out <= (isr_code != qup_pkg::QUP_ISR_NONE);
      int_oe_n <= ~(style | modem_ctrl_reg[qup_pkg::QUP_MCR_IRQ_EN]);
    end
  end
endmodule // qup_device

// ==== rtl/qup_host.sv ====
// Host end of one channel's bus: turns a user request into a strobe cycle.
// Assumes the device samples the bus through two flip-flops.
`timescale 1ns/1ps
module qup_host #(
  parameter int SETUP = 2,
  parameter int STROBE = 8,
  parameter int HOLD = 2
) (
  input wire logic clk,
  input wire logic reset,
  qup_if.host bus,
  input wire logic req,
  input wire logic wr,
  input wire logic [2:0] sel,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  qup_pkg::qup_hst_t st;
  logic [7:0] cnt;
  logic [7:0] b1;
  logic [7:0] b2;
  logic is_wr;

  if (SETUP < 2 || STROBE < 8 || HOLD < 2 || STROBE > 255)
  begin : g_chk
    $error("qup_host timing too short for the device synchronisers");
  end

  localparam logic [7:0] SETUP_LAST = 8'(SETUP - 1);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE - 1);
  localparam logic [7:0] HOLD_LAST = 8'(HOLD - 1);

  ////////////////////////////////////////////////////////////////
  // Read data is from the other party, so it is synchronised
  always_ff @(posedge clk)
  begin
    if (reset)
      {b1, b2} <= 16'h0000;
    else
    begin
      b1 <= bus.host_data_bus;
      b2 <= b1;
    end
  end

  // Bus cycle sequencer; select and address lead the strobe
  wire cnt_end = (st == qup_pkg::QUP_H_SETUP && cnt == SETUP_LAST) ||
                 (st == qup_pkg::QUP_H_STROBE && cnt == STROBE_LAST) ||
                 (st == qup_pkg::QUP_H_HOLD && cnt == HOLD_LAST);
  assign busy = (st != qup_pkg::QUP_H_IDLE);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= qup_pkg::QUP_H_IDLE;
      {cnt, rdata, done, is_wr} <= '0;
      {bus.cs_n, bus.write_strobe_n, bus.read_strobe_n, bus.host_oe_n} <= 4'hF;
      {bus.reg_sel_2, bus.reg_sel_1, bus.reg_sel_0} <= 3'h0;
      bus.host_dout <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      cnt <= cnt_end ? 8'h00 : cnt + 8'h01;
      unique case (st)
        qup_pkg::QUP_H_IDLE:
        begin
          cnt <= 8'h00;
          if (req)
          begin
            st <= qup_pkg::QUP_H_SETUP;
            is_wr <= wr;
            bus.cs_n <= 1'b0;
            {bus.reg_sel_2, bus.reg_sel_1, bus.reg_sel_0} <= sel;
            bus.host_dout <= wdata;
            bus.host_oe_n <= ~wr;
          end
        end
        qup_pkg::QUP_H_SETUP:
          if (cnt_end)
          begin
            st <= qup_pkg::QUP_H_STROBE;
            bus.write_strobe_n <= ~is_wr;
            bus.read_strobe_n <= is_wr;
          end
        qup_pkg::QUP_H_STROBE:
          if (cnt_end)
          begin
            st <= qup_pkg::QUP_H_HOLD;
            if (!is_wr)
              rdata <= b2;
            {bus.write_strobe_n, bus.read_strobe_n} <= 2'b11;
          end
        qup_pkg::QUP_H_HOLD:
          if (cnt_end)
          begin
            st <= qup_pkg::QUP_H_IDLE;
            done <= 1'b1;
            bus.cs_n <= 1'b1;
            bus.host_oe_n <= 1'b1;
          end
      endcase
    end
  end
endmodule // qup_host

// ==== sim/qup_assertions.sv ====
// Checker for one channel: bus drive, reset levels, pins.
// Assumes the bench wires it beside the host/device interface.
`timescale 1ns/1ps
module qup_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic reg_sel_2,
  input wire logic reg_sel_1,
  input wire logic reg_sel_0,
  input wire logic [7:0] host_data_bus,
  input wire logic dev_oe_n,
  input wire logic tx_out,
  input wire logic send_req_n,
  input wire logic term_ready_n,
  input wire logic irq_style_pin,
  input wire logic int_out,
  input wire logic int_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Modem control write seen on the pins
  wire mcr_wr = !cs_n && !write_strobe_n && {reg_sel_2, reg_sel_1, reg_sel_0} == qup_pkg::QUP_A_MCR;
  ////////////////////////////////////////
  // Drive follows the two-stage synced read
  AST_OE_CAUSE: assert property (!dev_oe_n |-> $past(cs_n, 2) == 0 && $past(read_strobe_n, 2) == 0)
    else $error("bus driven without selected read");
  AST_OE_READ: assert property ($fell(read_strobe_n) && !cs_n |-> ##[1:3] !dev_oe_n)
    else $error("read not answered");
  AST_OE_FREE: assert property (read_strobe_n [*3] |-> dev_oe_n)
    else $error("bus held after read");
  AST_CS_IGNORE: assert property (cs_n [*3] |-> dev_oe_n)
    else $error("unselected channel drives bus");
  // Levels right after reset
  AST_RST_MARK: assert property ($fell(reset) |-> tx_out)
    else $error("line not at mark after reset");
  AST_RST_MODEM: assert property ($fell(reset) |-> send_req_n && term_ready_n)
    else $error("modem pins low after reset");
  AST_RST_INT: assert property ($fell(reset) |-> !int_out && int_oe_n)
    else $error("interrupt active after reset");
  AST_IRQ_DRIVEN: assert property (irq_style_pin [*5] |-> !int_oe_n)
    else $error("interrupt floats with style high");
  AST_SEND_SET: assert property (mcr_wr && host_data_bus[1] |-> ##[1:6] !send_req_n)
    else $error("send request not low");
  AST_TERM_CLR: assert property (mcr_wr && !host_data_bus[0] |-> ##[1:6] term_ready_n)
    else $error("terminal ready not high");
endmodule // qup_assertions

// ==== sim/testbench.sv ====
// Bench: host end drives device end of one channel.
// Assumes design files and checker are compiled first.
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] DAT = qup_pkg::QUP_A_DATA;
  localparam logic [2:0] MODEM_CTRL_REG = qup_pkg::QUP_A_MCR;
  localparam logic [2:0] IER = qup_pkg::QUP_A_IER;
  logic clk, reset, req, wr, busy, done, rx_ext, irq_style_pin;
  logic [2:0] sel;
  logic [7:0] wdata, rdata;
  logic tx_out, send_req_n, term_ready_n, tx_space_n, rx_avail_n, int_out, int_oe_n;
  logic [7:0] lcr_tab [4] = '{8'h03, 8'h03, 8'h1B, 8'h0B};
  logic [7:0] dl_tab [4] = '{8'h02, 8'h01, 8'h01, 8'h01};
  int fails, samples_checked, n;
  // Line loops back to the receiver; rx_ext low spoils it
  wire rx_in = rx_ext & tx_out;
  qup_if bus_if();
  qup_host qup_host_inst (.clk(clk), .reset(reset), .bus(bus_if.host), .req(req), .wr(wr), .sel(sel),
    .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
  qup_device qup_device_inst (.clk(clk), .reset(reset), .bus(bus_if.dev), .rx_in(rx_in),
    .irq_style_pin(irq_style_pin), .tx_out(tx_out), .send_req_n(send_req_n), .term_ready_n(term_ready_n),
    .tx_space_n(tx_space_n), .rx_avail_n(rx_avail_n), .int_out(int_out), .int_oe_n(int_oe_n));
  qup_assertions qup_assertions_inst (.clk(clk), .reset(reset), .cs_n(bus_if.cs_n),
    .write_strobe_n(bus_if.write_strobe_n), .read_strobe_n(bus_if.read_strobe_n),
    .reg_sel_2(bus_if.reg_sel_2), .reg_sel_1(bus_if.reg_sel_1), .reg_sel_0(bus_if.reg_sel_0),
    .host_data_bus(bus_if.host_data_bus), .dev_oe_n(bus_if.dev_oe_n), .tx_out(tx_out),
    .send_req_n(send_req_n), .term_ready_n(term_ready_n), .irq_style_pin(irq_style_pin),
    .int_out(int_out), .int_oe_n(int_oe_n));
  ////////////////////////////////////////
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One host cycle; done is bounded so a stuck host cannot hang
  task automatic acc(input logic w, input logic [2:0] s, input logic [7:0] d);
    int k;
    @(posedge clk);
    #1;
    req = 1'b1;
    wr = w;
    sel = s;
    wdata = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    chk("busy", 8'(busy), 8'h01);
    k = 0;
    while (done !== 1'b1 && k < 40)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("done", 8'(k < 40), 8'h01);
    chk("busy end", 8'(busy), 8'h00);
  endtask
  // Samples each bit of a frame at mid bit; bt is the bit time in cycles
  task automatic frame(input logic [7:0] d, input logic [7:0] lc, input int bt);
    int k;
    k = 0;
    while (tx_out !== 1'b0 && k < 200)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (bt / 2) @(posedge clk);
    chk("start", 8'(tx_out), 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bt) @(posedge clk);
      chk("bit", 8'(tx_out), 8'(d[i]));
    end
    if (lc[qup_pkg::QUP_LCR_PEN])
    begin
      repeat (bt) @(posedge clk);
      chk("parity", 8'(tx_out), 8'(^d ^ !lc[qup_pkg::QUP_LCR_EVEN]));
    end
    repeat (bt) @(posedge clk);
    chk("stop", 8'(tx_out), 8'h01);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog, about twice the planned run
  initial
  begin
    repeat (25000) @(posedge clk);
    fails++;
    final_report();
  end
  ////////////////////////////////////////
  initial
  begin
    {reset, req, wr, sel, wdata, rx_ext, irq_style_pin, fails, samples_checked} = '0;
    reset = 1'b1;
    rx_ext = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("idle bus", bus_if.host_data_bus, 8'hFF);
    acc(1'b1, qup_pkg::QUP_A_SPR, 8'hA5);
    acc(1'b0, qup_pkg::QUP_A_SPR, 8'h00);
    chk("scratch", rdata, 8'hA5);
    // Divisor 2, then divisor 1 with no, even and odd parity, echoed through the line
    for (int p = 0; p < 4; p++)
    begin
      acc(1'b1, qup_pkg::QUP_A_LCR, 8'(1 << qup_pkg::QUP_LCR_DLAB));
      acc(1'b1, DAT, dl_tab[p]);
      acc(1'b1, qup_pkg::QUP_A_LCR, lcr_tab[p]);
      fork
        acc(1'b1, DAT, 8'h57);
        frame(8'h57, lcr_tab[p], 48 * int'(dl_tab[p]));
      join
      repeat (48 * int'(dl_tab[p])) @(posedge clk);
      acc(1'b0, DAT, 8'h00);
      chk("echo", rdata, 8'h57);
    end
    irq_style_pin = 1'b1;
    acc(1'b1, IER, 8'h02);
    chk("irq", {6'h00, int_out, int_oe_n}, 8'h02);
    irq_style_pin = 1'b0;
    acc(1'b1, MODEM_CTRL_REG, 8'h03);
    chk("pins", {5'h00, send_req_n, term_ready_n, int_oe_n}, 8'h01);
    acc(1'b1, MODEM_CTRL_REG, 8'h0B);
    chk("pins", {5'h00, send_req_n, term_ready_n, int_oe_n}, 8'h00);
    acc(1'b1, IER, 8'h00);
    chk("irq off", 8'(int_out), 8'h00);
    // Loopback: pin at space is ignored, queues fill to the edge
    acc(1'b1, MODEM_CTRL_REG, 8'h10);
    chk("pins", {5'h00, send_req_n, term_ready_n, int_oe_n}, 8'h07);
    rx_ext = 1'b0;
    for (int i = 0; i < 17; i++)
    begin
      acc(1'b1, DAT, 8'(i));
      if (i >= 15)
        chk("tx space", 8'(tx_space_n), 8'(i == 16));
    end
    n = 0;
    repeat (8800)
    begin
      @(posedge clk);
      n += int'(tx_out !== 1'b1);
    end
    chk("loop mark", 8'(n != 0), 8'h00);
    chk("rx full", 8'(rx_avail_n), 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b0, DAT, 8'h00);
      chk("loop data", rdata, 8'(i));
    end
    chk("rx room", 8'(rx_avail_n), 8'h01);
    final_report();
  end
endmodule // testbench
